// File: logic/mchp_host_port.sv
// Magnetometer threshold/repetition registers, measurement sequencer and shared host port pins
`timescale 1ns/1ps
module mchp_host_port
  import mchp_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic shared_clock_pin,
  input wire logic protocol_select_pin,
  input wire logic accel_select_pin,
  input wire logic gyro_select_pin,
  input wire logic mag_select_pin,
  input wire logic shared_data_pin_i,
  output logic shared_data_pin_o,
  output logic shared_data_pin_oe,
  input wire logic accel_mag_out_pin_i,
  output logic accel_mag_out_pin_o,
  output logic accel_mag_out_pin_oe,
  input wire logic gyro_out_pin_i,
  output logic gyro_out_pin_o,
  output logic gyro_out_pin_oe,
  input wire logic accel_read_bit,
  input wire logic gyro_read_bit,
  input wire logic three_wire_request,
  input wire logic measure_start,
  input wire logic rep_step,
  input wire logic [DATA_W-1:0] x_sample,
  input wire logic [DATA_W-1:0] y_sample,
  input wire logic [DATA_W-1:0] z_sample,
  output logic i2c_mode,
  output logic three_wire_mode,
  output logic accel_addr_lsb,
  output logic gyro_addr_lsb,
  output logic mag_addr_lsb,
  output logic accel_selected,
  output logic gyro_selected,
  output logic measure_busy,
  output logic measure_done,
  output logic [2:0] high_limit_hit
);
  initial
  begin
    if (DATA_W != 8)
      $error("mchp_host_port: sample width must match the 8-bit limit");
  end

  // Registers, clk domain
  logic [2:0] high_en_n;
  logic [2:0] chan_off;
  logic [7:0] upper_limit_value;
  logic [7:0] xy_repeat_field;
  logic [7:0] z_repeat_field;

  // Link-domain write request, held stable while its toggle crosses
  logic wr_toggle;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  // Pin and write-toggle synchronisers into clk
  logic [6:0] pins_sync;
  logic wr_toggle_seen;
  logic strap_taken;
  logic [1:0] strap_wait;
  logic spi_mode;
  logic wr_event;

  mchp_sync #(
    .WIDTH(7)
  ) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({wr_toggle, protocol_select_pin, accel_mag_out_pin_i, gyro_out_pin_i,
      mag_select_pin, accel_select_pin, gyro_select_pin}),
    .sync_out(pins_sync)
  );

  assign wr_event = pins_sync[6] ^ wr_toggle_seen;
  assign spi_mode = !i2c_mode;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wr_toggle_seen <= 1'b0;
    else
      wr_toggle_seen <= pins_sync[6];
  end

  // Waits until the synchroniser holds real pin levels, not its reset zeros
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      strap_wait <= 2'h0;
    else if (strap_wait != 2'(MCHP_SYNC_STAGES))
      strap_wait <= strap_wait + 2'h1;
  end

  // Straps caught once, after reset release, from synchronised levels
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_taken <= 1'b0;
      i2c_mode <= 1'b0;
      accel_addr_lsb <= 1'b0;
      gyro_addr_lsb <= 1'b0;
      mag_addr_lsb <= 1'b0;
    end
    else if (!strap_taken && strap_wait == 2'(MCHP_SYNC_STAGES))
    begin
      strap_taken <= 1'b1;
      i2c_mode <= pins_sync[5];
      accel_addr_lsb <= pins_sync[4];
      gyro_addr_lsb <= pins_sync[3];
      mag_addr_lsb <= pins_sync[2];
    end
  end

  // Active-low selects reach the inertial cores only in SPI
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      accel_selected <= 1'b0;
      gyro_selected <= 1'b0;
    end
    else
    begin
      accel_selected <= spi_mode && strap_taken && !pins_sync[1];
      gyro_selected <= spi_mode && strap_taken && !pins_sync[0];
    end
  end

  // 3-wire only on request; power-up form is 4-wire
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      three_wire_mode <= 1'b0;
    else if (three_wire_request)
      three_wire_mode <= 1'b1;
  end

  // Register writes from the host port
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      high_en_n <= MCHP_RST_HIGH_EN_N;
      chan_off <= MCHP_RST_CHAN_OFF;
      upper_limit_value <= MCHP_RST_HIGH_LIMIT;
      xy_repeat_field <= MCHP_RST_XY_REPEAT;
      z_repeat_field <= MCHP_RST_Z_REPEAT;
    end
    else if (wr_event)
    begin
      case (wr_addr)
        MCHP_OFS_INT_CTRL: high_en_n <= wr_data[MCHP_AXIS_FIELD_LSB +: 3];
        MCHP_OFS_AXIS_CTRL: chan_off <= wr_data[MCHP_AXIS_FIELD_LSB +: 3];
        MCHP_OFS_HIGH_LIMIT: upper_limit_value <= wr_data;
        MCHP_OFS_XY_REPEAT: xy_repeat_field <= wr_data;
        MCHP_OFS_Z_REPEAT: z_repeat_field <= wr_data;
        default: ;
      endcase
    end
  end

  // Measurement sequencer
  mchp_state_t state;
  logic [8:0] xy_repeat_total;
  logic [8:0] z_repeat_total;
  logic [2:0] run_off;
  logic seq_load;
  logic x_done;
  logic y_done;
  logic z_done;
  logic [DATA_W-1:0] last_x;
  logic [DATA_W-1:0] last_y;
  logic [DATA_W-1:0] last_z;

  assign xy_repeat_total = {xy_repeat_field, 1'b1};
  assign z_repeat_total = {1'b0, z_repeat_field} + 9'h001;
  assign seq_load = (state == MCHP_IDLE) && measure_start;

  // Counts are latched only at start, so a write never disturbs a running one
  mchp_rep_count #(
    .WIDTH(9)
  ) u_rep_x (
    .clk(clk),
    .reset_n(reset_n),
    .load(seq_load),
    .total(chan_off[0] ? 9'h000 : xy_repeat_total),
    .step(rep_step && state == MCHP_PHASE_X),
    .done(x_done)
  );

  mchp_rep_count #(
    .WIDTH(9)
  ) u_rep_y (
    .clk(clk),
    .reset_n(reset_n),
    .load(seq_load),
    .total(chan_off[1] ? 9'h000 : xy_repeat_total),
    .step(rep_step && state == MCHP_PHASE_Y),
    .done(y_done)
  );

  mchp_rep_count #(
    .WIDTH(9)
  ) u_rep_z (
    .clk(clk),
    .reset_n(reset_n),
    .load(seq_load),
    .total(chan_off[2] ? 9'h000 : z_repeat_total),
    .step(rep_step && state == MCHP_PHASE_Z),
    .done(z_done)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= MCHP_IDLE;
      run_off <= 3'h0;
      measure_done <= 1'b0;
    end
    else
    begin
      measure_done <= 1'b0;
      case (state)
        MCHP_IDLE:
          if (measure_start)
          begin
            state <= MCHP_PHASE_X;
            run_off <= chan_off;
          end
        MCHP_PHASE_X:
          if (x_done)
            state <= MCHP_PHASE_Y;
        MCHP_PHASE_Y:
          if (y_done)
            state <= MCHP_PHASE_Z;
        MCHP_PHASE_Z:
          if (z_done)
          begin
            state <= MCHP_IDLE;
            measure_done <= 1'b1;
          end
        default: state <= MCHP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      measure_busy <= 1'b0;
    else
      measure_busy <= (state != MCHP_IDLE && !(state == MCHP_PHASE_Z && z_done))
        || measure_start;
  end

  // Disabled channels keep their previous value
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_x <= '0;
      last_y <= '0;
      last_z <= '0;
    end
    else if (state == MCHP_PHASE_Z && z_done)
    begin
      if (!run_off[0])
        last_x <= x_sample;
      if (!run_off[1])
        last_y <= y_sample;
      if (!run_off[2])
        last_z <= z_sample;
    end
  end

  // Checked on held values even for disabled channels
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      high_limit_hit <= 3'h0;
    else
    begin
      high_limit_hit[0] <= !high_en_n[0] && last_x > upper_limit_value;
      high_limit_hit[1] <= !high_en_n[1] && last_y > upper_limit_value;
      high_limit_hit[2] <= !high_en_n[2] && last_z > upper_limit_value;
    end
  end

  // Link domain: SPI slave on the shared clock pin, framed by the mag select
  logic link_rst_n;
  logic [4:0] bit_cnt;
  logic frame_read;
  logic [6:0] frame_addr;
  logic [7:0] in_shift;
  logic [7:0] out_shift;
  logic [7:0] read_word;

  // Select high ends the frame; I2C keeps the SPI engine held in reset
  assign link_rst_n = reset_n && !mag_select_pin && !i2c_mode;

  function automatic logic [7:0] read_value(input logic [6:0] addr);
    logic [7:0] value;
    value = 8'h00;
    case (addr)
      MCHP_OFS_INT_STATUS: value[MCHP_AXIS_FIELD_LSB +: 3] = high_limit_hit;
      MCHP_OFS_INT_CTRL: value[MCHP_AXIS_FIELD_LSB +: 3] = high_en_n;
      MCHP_OFS_AXIS_CTRL: value[MCHP_AXIS_FIELD_LSB +: 3] = chan_off;
      MCHP_OFS_HIGH_LIMIT: value = upper_limit_value;
      MCHP_OFS_XY_REPEAT: value = xy_repeat_field;
      MCHP_OFS_Z_REPEAT: value = z_repeat_field;
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  always_comb
    read_word = read_value(frame_addr);

  // Host is master: it alone starts frames and clocks them
  always_ff @(posedge shared_clock_pin or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt <= 5'd0;
      frame_read <= 1'b0;
      frame_addr <= 7'h00;
      in_shift <= 8'h00;
    end
    else
    begin
      in_shift <= {in_shift[6:0], shared_data_pin_i};
      if (bit_cnt == 5'd0)
        frame_read <= shared_data_pin_i;
      if (bit_cnt == 5'(MCHP_FRAME_ADDR_BITS - 1))
        frame_addr <= {in_shift[5:0], shared_data_pin_i};
      else if (bit_cnt == MCHP_BIT_LAST_DATA && frame_read)
        frame_addr <= frame_addr + 7'h01;
      bit_cnt <= (bit_cnt == MCHP_BIT_LAST_DATA) ? MCHP_BIT_FIRST_DATA : bit_cnt + 5'd1;
    end
  end

  // Write capture survives the frame end; only the global reset clears it
  always_ff @(posedge shared_clock_pin or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_toggle <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end
    else if (link_rst_n && bit_cnt == MCHP_BIT_LAST_DATA && !frame_read)
    begin
      wr_toggle <= !wr_toggle;
      wr_addr <= frame_addr;
      wr_data <= {in_shift[6:0], shared_data_pin_i};
    end
  end

  // Read data launched on falling edges; register words are quasi-static here
  always_ff @(negedge shared_clock_pin or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      out_shift <= 8'h00;
    end
    else if (frame_read && bit_cnt >= MCHP_BIT_FIRST_DATA)
    begin
      if (bit_cnt == MCHP_BIT_FIRST_DATA)
        out_shift <= read_word;
      else
        out_shift <= {out_shift[6:0], 1'b0};
    end
  end

  // Pin drivers: accel and mag share one output, gyro has its own
  always_ff @(negedge shared_clock_pin or negedge reset_n)
  begin
    if (!reset_n)
    begin
      accel_mag_out_pin_o <= 1'b0;
      accel_mag_out_pin_oe <= 1'b0;
      gyro_out_pin_o <= 1'b0;
      gyro_out_pin_oe <= 1'b0;
    end
    else
    begin
      accel_mag_out_pin_o <= !accel_select_pin ? accel_read_bit :
        (frame_read && bit_cnt == MCHP_BIT_FIRST_DATA) ? read_word[7] : out_shift[6];
      accel_mag_out_pin_oe <= spi_mode && !three_wire_mode &&
        (!accel_select_pin || (link_rst_n && frame_read && bit_cnt >= MCHP_BIT_FIRST_DATA));
      gyro_out_pin_o <= gyro_read_bit;
      gyro_out_pin_oe <= spi_mode && !three_wire_mode && !gyro_select_pin;
    end
  end

  // Select high releases the shared data pin at once; no clock edge follows a frame
  always_ff @(negedge shared_clock_pin or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      shared_data_pin_o <= 1'b0;
      shared_data_pin_oe <= 1'b0;
    end
    else
    begin
      shared_data_pin_o <= (bit_cnt == MCHP_BIT_FIRST_DATA) ? read_word[7] : out_shift[6];
      shared_data_pin_oe <= spi_mode && three_wire_mode && frame_read &&
        bit_cnt >= MCHP_BIT_FIRST_DATA;
    end
  end
endmodule

// File: logic/mchp_pkg.sv
// Constants and shared types for the magnetometer configuration and host port block
// Overview of operation
// - Register 0x50 holds an 8-bit writable high-threshold limit, bits 7..0.
// - X and y axes each repeat one plus twice the xy repeat field times.
// - Z axis repeats one plus the z repeat field times, 1 to 256.
// - SPI starts in 4-wire form; 3-wire only after a software request.
// - Device is always a bus slave; host is master on both protocols.
// - Accelerometer and gyroscope have their own pins, usable independently.
// - 4-wire SPI: accel/mag data on accel/mag pin, gyro data on gyro pin.
// - I2C: accel address LSB comes from the accel/mag output pin level.
// - I2C: gyro address LSB comes from the gyro output pin level.
// - Mag select pin: I2C mag address LSB, SPI magnetometer select.
// - Shared data pin: SPI input, 3-wire bidirectional data, I2C data line.
// - Separate accel and gyro selects in SPI, both ignored in I2C.
// - Shared clock pin carries SPI clock in SPI and I2C clock in I2C.
// - Per-axis high-threshold detect enable is active low, disabled after reset.
// - Disabled axes keep being checked against their last measured value.
package mchp_pkg;
  localparam logic [6:0] MCHP_OFS_INT_STATUS = 7'h4A;
  localparam logic [6:0] MCHP_OFS_INT_CTRL = 7'h4D;
  localparam logic [6:0] MCHP_OFS_AXIS_CTRL = 7'h4E;
  localparam logic [6:0] MCHP_OFS_HIGH_LIMIT = 7'h50;
  localparam logic [6:0] MCHP_OFS_XY_REPEAT = 7'h51;
  localparam logic [6:0] MCHP_OFS_Z_REPEAT = 7'h52;
  localparam int MCHP_AXIS_FIELD_LSB = 3;
  localparam logic [2:0] MCHP_RST_HIGH_EN_N = 3'h7;
  localparam logic [2:0] MCHP_RST_CHAN_OFF = 3'h0;
  localparam logic [7:0] MCHP_RST_HIGH_LIMIT = 8'h00;
  localparam logic [7:0] MCHP_RST_XY_REPEAT = 8'h00;
  localparam logic [7:0] MCHP_RST_Z_REPEAT = 8'h00;
  localparam int MCHP_FRAME_ADDR_BITS = 8;
  localparam logic [4:0] MCHP_BIT_FIRST_DATA = 5'd8;
  localparam logic [4:0] MCHP_BIT_LAST_DATA = 5'd15;
  localparam int MCHP_SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    MCHP_IDLE = 2'b00,
    MCHP_PHASE_X = 2'b01,
    MCHP_PHASE_Y = 2'b11,
    MCHP_PHASE_Z = 2'b10
  } mchp_state_t;
endpackage

// File: logic/mchp_sync.sv
// Two-stage synchroniser for a group of independent levels
`timescale 1ns/1ps
module mchp_sync
  import mchp_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_a;

  initial
  begin
    if (WIDTH < 1 || MCHP_SYNC_STAGES != 2)
      $error("mchp_sync: unsupported width");
  end

  // First stage feeds only the second
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage_a <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage_a <= async_in;
      sync_out <= stage_a;
    end
  end
endmodule

// File: logic/mchp_rep_count.sv
// Down counter of remaining repetitions for one measurement axis
`timescale 1ns/1ps
module mchp_rep_count #(
  parameter int WIDTH = 9
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] total,
  input wire logic step,
  output logic done
);
  logic [WIDTH-1:0] remaining;

  initial
  begin
    if (WIDTH < 9)
      $error("mchp_rep_count: width too small for 511 repetitions");
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      remaining <= '0;
    else if (load)
      remaining <= total;
    else if (step && remaining != '0)
      remaining <= remaining - 1'b1;
  end

  assign done = (remaining == '0);
endmodule

// File: verification/mchp_spi_host_model.sv
// Behavioural SPI master standing in for the host processor
`timescale 1ns/1ps
module mchp_spi_host_model (
  output logic sck,
  output logic sel_n,
  output logic mosi,
  input wire logic miso_4w,
  input wire logic miso_3w
);
  initial
  begin
    sck = 1'b1;
    sel_n = 1'b1;
    mosi = 1'b1;
  end

  // Mode 11 frame; clock idles high and stands still between frames
  task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wd,
    input logic use3, output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {rd, addr, wd};
    rdat = 8'h00;
    sel_n = 1'b0;
    #20;
    for (int i = 15; i >= 0; i--)
    begin
      sck = 1'b0;
      // Released during read data: toggle so no stale level looks valid
      mosi = (rd && i < 8) ? ~mosi : sh[i];
      #15;
      sck = 1'b1;
      if (i < 8)
        rdat[i] = use3 ? miso_3w : miso_4w;
      #15;
    end
    #40;
    sel_n = 1'b1;
    mosi = ~mosi;
    // Idle gap lets the write cross into the register clock
    #70;
  endtask
endmodule

// File: verification/mchp_host_port_chk.sv
// Assertions on the host port pins and measurement sequencer
`timescale 1ns/1ps
module mchp_host_port_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic accel_select_pin,
  input wire logic three_wire_request,
  input wire logic measure_start,
  input wire logic shared_data_pin_oe,
  input wire logic accel_mag_out_pin_oe,
  input wire logic gyro_out_pin_oe,
  input wire logic i2c_mode,
  input wire logic three_wire_mode,
  input wire logic accel_selected,
  input wire logic gyro_selected,
  input wire logic measure_busy,
  input wire logic measure_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_done_one_cycle: assert property (measure_done |=> !measure_done)
    else $error("measure_done longer than one cycle");
  a_done_ends_busy: assert property (measure_done |-> !measure_busy && $past(measure_busy))
    else $error("measure_done without a running measurement");
  a_busy_fall_done: assert property ($fell(measure_busy) |-> measure_done)
    else $error("measurement ended without measure_done");
  a_start_sets_busy: assert property (measure_start && !measure_busy && !measure_done
    |=> measure_busy)
    else $error("accepted start did not raise busy");
  a_three_sticky: assert property (three_wire_mode |=> three_wire_mode)
    else $error("three-wire mode dropped");
  a_three_set: assert property (three_wire_request |-> ##[1:4] three_wire_mode)
    else $error("three-wire request not taken");
  a_sdi_input_4w: assert property (!three_wire_mode |-> !shared_data_pin_oe)
    else $error("data pin driven in four-wire mode");
  a_i2c_pins_idle: assert property (i2c_mode |-> !accel_mag_out_pin_oe && !gyro_out_pin_oe
    && !shared_data_pin_oe)
    else $error("strap pin driven in I2C mode");
  a_i2c_no_select: assert property (i2c_mode |-> !accel_selected && !gyro_selected)
    else $error("select honoured in I2C mode");
  a_accel_sel: assert property (!accel_select_pin [*6] ##0 !i2c_mode |-> accel_selected)
    else $error("accel select not seen in SPI mode");
endmodule

bind mchp_host_port mchp_host_port_chk u_chk (
  .clk(clk), .reset_n(reset_n), .accel_select_pin(accel_select_pin),
  .three_wire_request(three_wire_request), .measure_start(measure_start),
  .shared_data_pin_oe(shared_data_pin_oe), .accel_mag_out_pin_oe(accel_mag_out_pin_oe),
  .gyro_out_pin_oe(gyro_out_pin_oe), .i2c_mode(i2c_mode), .three_wire_mode(three_wire_mode),
  .accel_selected(accel_selected), .gyro_selected(gyro_selected),
  .measure_busy(measure_busy), .measure_done(measure_done)
);

// File: verification/tb_mchp_host_port.sv
// Self-checking bench for the magnetometer configuration and host port block
`timescale 1ns/1ps
module tb_mchp_host_port;
  import mchp_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic protocol_select_pin = 1'b0;
  logic accel_select_pin = 1'b1;
  logic gyro_select_pin = 1'b1;
  logic am_strap = 1'b1;
  logic g_strap = 1'b0;
  logic mag_strap = 1'b1;
  logic three_wire_request = 1'b0;
  logic measure_start = 1'b0;
  logic rep_step = 1'b0;
  logic tw = 1'b0;
  logic [7:0] x_sample = 8'h41;
  logic [7:0] y_sample = 8'h40;
  logic [7:0] z_sample = 8'h80;
  logic sck, sel_n, mosi, sdo_o, sdo_oe, am_o, am_oe, g_o, g_oe;
  logic i2c_mode, three_wire_mode, accel_addr_lsb, gyro_addr_lsb, mag_addr_lsb;
  logic accel_selected, gyro_selected, measure_busy, measure_done;
  logic [2:0] high_limit_hit;
  logic [7:0] rdat;
  wire sdi_wire = sdo_oe ? sdo_o : mosi;
  wire am_wire = am_oe ? am_o : am_strap;
  wire g_wire = g_oe ? g_o : g_strap;
  int failures = 0;
  int n_compared = 0;
  int done_cnt = 0;

  always #5 clk = ~clk;
  always @(posedge clk)
    if (measure_done === 1'b1)
      done_cnt <= done_cnt + 1;

  mchp_spi_host_model u_host (.sck(sck), .sel_n(sel_n), .mosi(mosi), .miso_4w(am_wire),
    .miso_3w(sdi_wire));

  mchp_host_port u_dut (.clk(clk), .reset_n(reset_n), .shared_clock_pin(sck),
    .protocol_select_pin(protocol_select_pin), .accel_select_pin(accel_select_pin),
    .gyro_select_pin(gyro_select_pin), .mag_select_pin(sel_n & mag_strap),
    .shared_data_pin_i(sdi_wire), .shared_data_pin_o(sdo_o), .shared_data_pin_oe(sdo_oe),
    .accel_mag_out_pin_i(am_wire), .accel_mag_out_pin_o(am_o), .accel_mag_out_pin_oe(am_oe),
    .gyro_out_pin_i(g_wire), .gyro_out_pin_o(g_o), .gyro_out_pin_oe(g_oe),
    .accel_read_bit(1'b1), .gyro_read_bit(1'b1), .three_wire_request(three_wire_request),
    .measure_start(measure_start), .rep_step(rep_step), .x_sample(x_sample),
    .y_sample(y_sample), .z_sample(z_sample), .i2c_mode(i2c_mode),
    .three_wire_mode(three_wire_mode), .accel_addr_lsb(accel_addr_lsb),
    .gyro_addr_lsb(gyro_addr_lsb), .mag_addr_lsb(mag_addr_lsb),
    .accel_selected(accel_selected), .gyro_selected(gyro_selected),
    .measure_busy(measure_busy), .measure_done(measure_done),
    .high_limit_hit(high_limit_hit));

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Counts: %0d compared, %0d failed", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic ps, input logic am, input logic g, input logic m);
    protocol_select_pin = ps;
    am_strap = am;
    g_strap = g;
    mag_strap = m;
    reset_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.frame(1'b0, a, d, tw, rdat);
  endtask

  task automatic rd(input string nm, input logic [6:0] a, input logic [7:0] exp);
    u_host.frame(1'b1, a, 8'h00, tw, rdat);
    chk(nm, rdat, exp);
  endtask

  task automatic steps(input int n);
    for (int i = 0; i < n; i++)
    begin
      rep_step = 1'b1;
      @(posedge clk);
      #1;
      rep_step = 1'b0;
      @(posedge clk);
      #1;
    end
  endtask

  // Step count n; a repeat write lands after k steps when k is non-zero
  task automatic meas(input string nm, input int n, input int k);
    int base;
    base = done_cnt;
    measure_start = 1'b1;
    @(posedge clk);
    #1;
    measure_start = 1'b0;
    // An axis with no repetitions still spends one cycle in its phase
    @(posedge clk);
    #1;
    steps(k);
    if (k > 0)
      wr(MCHP_OFS_XY_REPEAT, 8'h03);
    steps(n - k - 1);
    chk({nm, "_early"}, 8'(done_cnt - base), 8'h00);
    steps(1);
    repeat (4) @(posedge clk);
    #1;
    chk(nm, 8'(done_cnt - base), 8'h01);
    chk({nm, "_busy"}, measure_busy, 8'h00);
    $display("Test %s done", nm);
  endtask

  logic [7:0] rep_xy [4] = '{8'h00, 8'h02, 8'hFF, 8'h01};
  logic [7:0] rep_z [4] = '{8'h00, 8'h03, 8'hFF, 8'h00};
  int rep_n [4] = '{3, 14, 1278, 7};
  int rep_k [4] = '{0, 0, 0, 2};

  initial
  begin
    do_reset(1'b0, 1'b1, 1'b0, 1'b1);
    chk("i2c_mode", i2c_mode, 8'h00);
    chk("am_lsb", accel_addr_lsb, 8'h01);
    chk("g_lsb", gyro_addr_lsb, 8'h00);
    chk("m_lsb", mag_addr_lsb, 8'h01);
    chk("three_wire", three_wire_mode, 8'h00);
    accel_select_pin = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("accel_sel", accel_selected, 8'h01);
    chk("gyro_sel", gyro_selected, 8'h00);
    accel_select_pin = 1'b1;
    gyro_select_pin = 1'b0;
    $display("Test straps done");
    rd("rst_limit", MCHP_OFS_HIGH_LIMIT, MCHP_RST_HIGH_LIMIT);
    chk("gyro_oe", g_oe, 8'h01);
    chk("gyro_data", g_wire, 8'h01);
    gyro_select_pin = 1'b1;
    rd("rst_xy", MCHP_OFS_XY_REPEAT, MCHP_RST_XY_REPEAT);
    rd("rst_z", MCHP_OFS_Z_REPEAT, MCHP_RST_Z_REPEAT);
    rd("rst_int", MCHP_OFS_INT_CTRL, 8'h38);
    rd("rst_axis", MCHP_OFS_AXIS_CTRL, 8'h00);
    rd("unmapped", 7'h7F, 8'h00);
    wr(7'h7F, 8'hFF);
    rd("unmapped_wr", 7'h7F, 8'h00);
    foreach (rep_xy[i])
    begin
      wr(MCHP_OFS_HIGH_LIMIT, ~rep_xy[i] ^ 8'h5A);
      rd("limit_rw", MCHP_OFS_HIGH_LIMIT, ~rep_xy[i] ^ 8'h5A);
    end
    $display("Test registers done");
    foreach (rep_xy[i])
    begin
      wr(MCHP_OFS_XY_REPEAT, rep_xy[i]);
      wr(MCHP_OFS_Z_REPEAT, rep_z[i]);
      meas("reps", rep_n[i], rep_k[i]);
    end
    meas("reps_next", 15, 0);
    wr(MCHP_OFS_XY_REPEAT, 8'h00);
    wr(MCHP_OFS_HIGH_LIMIT, 8'h40);
    meas("hit_off", 3, 0);
    chk("hit_off", high_limit_hit, 8'h00);
    wr(MCHP_OFS_INT_CTRL, 8'h00);
    meas("hit_on", 3, 0);
    chk("hit_on", high_limit_hit, 8'h05);
    rd("status", MCHP_OFS_INT_STATUS, 8'h28);
    wr(MCHP_OFS_AXIS_CTRL, 8'h08);
    x_sample = 8'h00;
    meas("x_off", 2, 0);
    chk("hit_last", high_limit_hit, 8'h05);
    three_wire_request = 1'b1;
    @(posedge clk);
    #1;
    three_wire_request = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("three_wire_on", three_wire_mode, 8'h01);
    tw = 1'b1;
    wr(MCHP_OFS_Z_REPEAT, 8'hC3);
    rd("rd_3w", MCHP_OFS_Z_REPEAT, 8'hC3);
    rd("rd_3w_limit", MCHP_OFS_HIGH_LIMIT, 8'h40);
    $display("Test three wire done");
    tw = 1'b0;
    do_reset(1'b1, 1'b0, 1'b1, 1'b0);
    chk("i2c_on", i2c_mode, 8'h01);
    chk("i2c_am_lsb", accel_addr_lsb, 8'h00);
    chk("i2c_g_lsb", gyro_addr_lsb, 8'h01);
    chk("i2c_m_lsb", mag_addr_lsb, 8'h00);
    chk("i2c_three_wire", three_wire_mode, 8'h00);
    accel_select_pin = 1'b0;
    gyro_select_pin = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("i2c_accel_sel", accel_selected, 8'h00);
    chk("i2c_gyro_sel", gyro_selected, 8'h00);
    $display("Test i2c straps done");
    final_report();
  end
endmodule
